// ---- rtl/ipr_pkg.sv ----
package ipr_pkg;
   // ==========================================================
   // Register offsets, one byte address each.
   // ==========================================================
   localparam logic [6:0] ADDR_ST_GYRO_X  = 7'h00;
   localparam logic [6:0] ADDR_ST_GYRO_Y  = 7'h01;
   localparam logic [6:0] ADDR_ST_GYRO_Z  = 7'h02;
   localparam logic [6:0] ADDR_ST_ACCEL_X = 7'h0D;
   localparam logic [6:0] ADDR_ST_ACCEL_Y = 7'h0E;
   localparam logic [6:0] ADDR_ST_ACCEL_Z = 7'h0F;
   localparam logic [6:0] ADDR_PWR_ONE    = 7'h6B;
   localparam logic [6:0] ADDR_PWR_TWO    = 7'h6C;
   localparam logic [6:0] ADDR_LEVEL_HIGH = 7'h72;
   localparam logic [6:0] ADDR_LEVEL_LOW  = 7'h73;
   localparam logic [6:0] ADDR_DATA_PORT  = 7'h74;
   localparam logic [6:0] ADDR_IDENTITY   = 7'h75;
   localparam logic [6:0] ADDR_TRIM_X_HI  = 7'h77;
   localparam logic [6:0] ADDR_TRIM_X_LO  = 7'h78;
   localparam logic [6:0] ADDR_TRIM_Y_HI  = 7'h7A;
   localparam logic [6:0] ADDR_TRIM_Y_LO  = 7'h7B;
   localparam logic [6:0] ADDR_TRIM_Z_HI  = 7'h7D;
   localparam logic [6:0] ADDR_TRIM_Z_LO  = 7'h7E;

   // ==========================================================
   // Field positions and widths.
   // ==========================================================
   localparam int PWR_RESET_BIT   = 7;
   localparam int PWR_SLEEP_BIT   = 6;
   localparam int PWR_CYCLE_BIT   = 5;
   localparam int PWR_RIDLE_BIT   = 4;
   localparam int PWR_THERM_BIT   = 3;
   localparam int LEVEL_WIDTH     = 13;
   localparam int TRIM_WIDTH      = 15;
   localparam int TRIM_LOW_BITS   = 7;
   localparam int AXES            = 3;

   // ==========================================================
   // Reset values.
   // ==========================================================
   localparam logic [7:0] ZERO_BYTE      = 8'h00;
   // Power-control-one default; a plain choice, adjustable here.
   localparam logic [7:0] PWR_ONE_RESET  = 8'h40;
   // Identity value is arbitrary.
   localparam logic [7:0] IDENTITY_VALUE = 8'hA5;
   // Factory images; arbitrary neutral values.
   localparam logic [7:0]  ST_GYRO_DEFAULT  = 8'h80;
   localparam logic [7:0]  ST_ACCEL_DEFAULT = 8'h70;
   localparam logic [14:0] TRIM_DEFAULT     = 15'h0000;
endpackage

// ---- rtl/ipr_byte_reg.sv ----
`timescale 1ns/10ps
// ==========================================================
// One writable byte with a factory image loaded at reset.
// ==========================================================
module ipr_byte_reg #(
   parameter logic [7:0] RESET_VALUE = 8'h00
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       we,
   input  wire logic [7:0] wdata,
   output logic      [7:0] q
);
   logic [7:0] q_next;  // Next held value.

   // Write takes the new byte, otherwise hold.
   always_comb
   begin
      q_next = we ? wdata : q;
   end

   // Reset loads the constant image.
   always_ff @(posedge clk)
   begin
      if (rst)
         q <= RESET_VALUE;
      else
         q <= q_next;
   end
endmodule

// ---- rtl/ipr_trim_reg.sv ----
`timescale 1ns/10ps
// ==========================================================
// One 15-bit accelerometer trim value split over two bytes.
// ==========================================================
module ipr_trim_reg #(
   parameter logic [14:0] RESET_VALUE = 15'h0000
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        we_high,
   input  wire logic        we_low,
   input  wire logic [7:0]  wdata,
   output logic      [7:0]  high_byte,
   output logic      [7:0]  low_byte
);
   logic [14:0] trim_reg;   // Held trim value.
   logic [14:0] trim_next;  // Its next value.

   // High byte writes bits 14..7, low byte bits 6..0 from 7..1.
   always_comb
   begin
      trim_next = trim_reg;
      if (we_high)
         trim_next[14:7] = wdata;  // [R10]
      if (we_low)
         trim_next[6:0] = wdata[7:1];  // [R10]
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         trim_reg <= RESET_VALUE;  // [R3]
      else
         trim_reg <= trim_next;
   end

   // Bit 0 of the low byte is unused and reads zero.
   assign high_byte = trim_reg[14:7];  // [R5] [R10]
   assign low_byte  = {trim_reg[6:0], 1'b0};  // [R10]
endmodule

// ---- rtl/ipr_regs.sv ----
`timescale 1ns/10ps
// Operation
// (R1) Other registers reset to zero.
// (R2) Self-test registers load factory values at reset.
// (R3) Trim registers load factory offsets at reset.
// (R4) Power-control-one resets to a non-zero default.
// (R5) High register upper byte, low lower byte.
// (R6) Self-test bytes hold manufacturing codes.
// (R7) Host converts codes to LSB values.
// (R8) Power-control-one bit layout fixed.
// (R9) Queue level: read-only 13 bits, split.
// (R10) Trim is 15 bits, low bit0 unused.
// (R11) Sleeping: only power-control writes take effect.
module ipr_regs #(
   parameter logic [7:0]  ST_GX = ipr_pkg::ST_GYRO_DEFAULT,
   parameter logic [7:0]  ST_GY = ipr_pkg::ST_GYRO_DEFAULT,
   parameter logic [7:0]  ST_GZ = ipr_pkg::ST_GYRO_DEFAULT,
   parameter logic [7:0]  ST_AX = ipr_pkg::ST_ACCEL_DEFAULT,
   parameter logic [7:0]  ST_AY = ipr_pkg::ST_ACCEL_DEFAULT,
   parameter logic [7:0]  ST_AZ = ipr_pkg::ST_ACCEL_DEFAULT,
   parameter logic [14:0] TRIM_X = ipr_pkg::TRIM_DEFAULT,
   parameter logic [14:0] TRIM_Y = ipr_pkg::TRIM_DEFAULT,
   parameter logic [14:0] TRIM_Z = ipr_pkg::TRIM_DEFAULT
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   input  wire logic [6:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic [12:0] queue_level,
   input  wire logic [7:0]  queue_rd_byte,
   output logic      [7:0]  rdata,
   output logic             queue_pop,
   output logic             queue_push,
   output logic      [7:0]  queue_wr_byte,
   output logic             device_reset_req,
   output logic             sleep_mode,
   output logic             accel_duty_cycling,
   output logic             rate_sensor_idle,
   output logic             thermometer_off,
   output logic      [2:0]  clock_source_select,
   output logic      [7:0]  power_control_two
);
   // ==========================================================
   // Power control state.
   // ==========================================================
   logic [7:0] pwr_one_reg;   // First power-control register.
   logic [7:0] pwr_one_next;  // Its next value.
   logic [7:0] pwr_two_reg;   // Second power-control register.
   logic [7:0] pwr_two_next;  // Its next value.
   logic       awake;         // High when not sleeping.

   assign awake = ~pwr_one_reg[ipr_pkg::PWR_SLEEP_BIT];

   // Power-control writes stay accepted while sleeping, so the host
   // can always wake the part. The reset bit is self-clearing: it
   // asks for one pulse and then reloads the default.
   always_comb
   begin
      pwr_one_next = pwr_one_reg;
      pwr_two_next = pwr_two_reg;
      if (pwr_one_reg[ipr_pkg::PWR_RESET_BIT])
      begin
         // Device reset reloads both registers.
         pwr_one_next = ipr_pkg::PWR_ONE_RESET;  // [R4]
         pwr_two_next = ipr_pkg::ZERO_BYTE;      // [R1]
      end
      else if (wr_en && addr == ipr_pkg::ADDR_PWR_ONE)
         pwr_one_next = wdata;  // [R8] [R11]
      else if (wr_en && addr == ipr_pkg::ADDR_PWR_TWO)
         pwr_two_next = wdata;  // [R11]
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pwr_one_reg <= ipr_pkg::PWR_ONE_RESET;  // [R4]
         pwr_two_reg <= ipr_pkg::ZERO_BYTE;      // [R1]
      end
      else
      begin
         pwr_one_reg <= pwr_one_next;
         pwr_two_reg <= pwr_two_next;
      end
   end

   // ==========================================================
   // Write strobes for the factory-loaded registers.
   // ==========================================================
   logic wr_ok;  // Writes outside power control need the part awake.
   assign wr_ok = wr_en && awake;  // [R11]

   logic [7:0] st_gx, st_gy, st_gz, st_ax, st_ay, st_az;
   logic [7:0] tx_h, tx_l, ty_h, ty_l, tz_h, tz_l;

   // Self-test bytes: factory image at reset, writable later.
   ipr_byte_reg #(.RESET_VALUE(ST_GX)) u_st_gx
   (
      .clk(clk), .rst(rst), .wdata(wdata), .q(st_gx),
      .we(wr_ok && addr == ipr_pkg::ADDR_ST_GYRO_X)  // [R2] [R6]
   );
   ipr_byte_reg #(.RESET_VALUE(ST_GY)) u_st_gy
   (
      .clk(clk), .rst(rst), .wdata(wdata), .q(st_gy),
      .we(wr_ok && addr == ipr_pkg::ADDR_ST_GYRO_Y)  // [R2] [R6]
   );
   ipr_byte_reg #(.RESET_VALUE(ST_GZ)) u_st_gz
   (
      .clk(clk), .rst(rst), .wdata(wdata), .q(st_gz),
      .we(wr_ok && addr == ipr_pkg::ADDR_ST_GYRO_Z)  // [R2] [R6]
   );
   ipr_byte_reg #(.RESET_VALUE(ST_AX)) u_st_ax
   (
      .clk(clk), .rst(rst), .wdata(wdata), .q(st_ax),
      .we(wr_ok && addr == ipr_pkg::ADDR_ST_ACCEL_X)  // [R2] [R6]
   );
   ipr_byte_reg #(.RESET_VALUE(ST_AY)) u_st_ay
   (
      .clk(clk), .rst(rst), .wdata(wdata), .q(st_ay),
      .we(wr_ok && addr == ipr_pkg::ADDR_ST_ACCEL_Y)  // [R2] [R6]
   );
   ipr_byte_reg #(.RESET_VALUE(ST_AZ)) u_st_az
   (
      .clk(clk), .rst(rst), .wdata(wdata), .q(st_az),
      .we(wr_ok && addr == ipr_pkg::ADDR_ST_ACCEL_Z)  // [R2] [R6]
   );

   // Trim pairs keep the upper byte high and the lower byte low.
   ipr_trim_reg #(.RESET_VALUE(TRIM_X)) u_trim_x
   (
      .clk(clk), .rst(rst), .wdata(wdata),
      .we_high(wr_ok && addr == ipr_pkg::ADDR_TRIM_X_HI),  // [R3]
      .we_low(wr_ok && addr == ipr_pkg::ADDR_TRIM_X_LO),
      .high_byte(tx_h), .low_byte(tx_l)
   );
   ipr_trim_reg #(.RESET_VALUE(TRIM_Y)) u_trim_y
   (
      .clk(clk), .rst(rst), .wdata(wdata),
      .we_high(wr_ok && addr == ipr_pkg::ADDR_TRIM_Y_HI),  // [R3]
      .we_low(wr_ok && addr == ipr_pkg::ADDR_TRIM_Y_LO),
      .high_byte(ty_h), .low_byte(ty_l)
   );
   ipr_trim_reg #(.RESET_VALUE(TRIM_Z)) u_trim_z
   (
      .clk(clk), .rst(rst), .wdata(wdata),
      .we_high(wr_ok && addr == ipr_pkg::ADDR_TRIM_Z_HI),  // [R3]
      .we_low(wr_ok && addr == ipr_pkg::ADDR_TRIM_Z_LO),
      .high_byte(tz_h), .low_byte(tz_l)
   );

   // ==========================================================
   // Read mux and queue strobes, registered.
   // ==========================================================
   logic [7:0] rdata_next;       // Byte for the next read answer.
   logic       pop_next;         // Data-port read pops one byte.
   logic       push_next;        // Data-port write pushes one byte.
   logic [7:0] push_byte_next;   // Byte pushed.

   // Unmapped addresses read zero. The data port pops only on a
   // read; pushes are ignored while sleeping.
   always_comb
   begin
      pop_next       = rd_en && addr == ipr_pkg::ADDR_DATA_PORT;
      push_next      = wr_ok && addr == ipr_pkg::ADDR_DATA_PORT;
      push_byte_next = push_next ? wdata : queue_wr_byte;
      unique case (addr)
         ipr_pkg::ADDR_ST_GYRO_X:  rdata_next = st_gx;
         ipr_pkg::ADDR_ST_GYRO_Y:  rdata_next = st_gy;
         ipr_pkg::ADDR_ST_GYRO_Z:  rdata_next = st_gz;
         ipr_pkg::ADDR_ST_ACCEL_X: rdata_next = st_ax;
         ipr_pkg::ADDR_ST_ACCEL_Y: rdata_next = st_ay;
         ipr_pkg::ADDR_ST_ACCEL_Z: rdata_next = st_az;
         ipr_pkg::ADDR_PWR_ONE:    rdata_next = pwr_one_reg;
         ipr_pkg::ADDR_PWR_TWO:    rdata_next = pwr_two_reg;
         // Top three bits of the high level byte are unused.
         ipr_pkg::ADDR_LEVEL_HIGH:
            rdata_next = {3'h0, queue_level[12:8]};  // [R9] [R5]
         ipr_pkg::ADDR_LEVEL_LOW:
            rdata_next = queue_level[7:0];  // [R9] [R5]
         ipr_pkg::ADDR_DATA_PORT:  rdata_next = queue_rd_byte;
         ipr_pkg::ADDR_IDENTITY:   rdata_next = ipr_pkg::IDENTITY_VALUE;
         ipr_pkg::ADDR_TRIM_X_HI:  rdata_next = tx_h;
         ipr_pkg::ADDR_TRIM_X_LO:  rdata_next = tx_l;
         ipr_pkg::ADDR_TRIM_Y_HI:  rdata_next = ty_h;
         ipr_pkg::ADDR_TRIM_Y_LO:  rdata_next = ty_l;
         ipr_pkg::ADDR_TRIM_Z_HI:  rdata_next = tz_h;
         ipr_pkg::ADDR_TRIM_Z_LO:  rdata_next = tz_l;
         default:                  rdata_next = ipr_pkg::ZERO_BYTE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rdata         <= ipr_pkg::ZERO_BYTE;  // [R1]
         queue_pop     <= 1'b0;
         queue_push    <= 1'b0;
         queue_wr_byte <= ipr_pkg::ZERO_BYTE;
      end
      else
      begin
         rdata         <= rdata_next;
         queue_pop     <= pop_next;
         queue_push    <= push_next;
         queue_wr_byte <= push_byte_next;
      end
   end

   // ==========================================================
   // Power-control fields decoded to the rest of the part.
   // ==========================================================
   // These are straight flip-flop bits of the two registers.
   assign device_reset_req    = pwr_one_reg[ipr_pkg::PWR_RESET_BIT]; // [R8]
   assign sleep_mode          = pwr_one_reg[ipr_pkg::PWR_SLEEP_BIT]; // [R8]
   assign accel_duty_cycling  = pwr_one_reg[ipr_pkg::PWR_CYCLE_BIT]; // [R8]
   assign rate_sensor_idle    = pwr_one_reg[ipr_pkg::PWR_RIDLE_BIT]; // [R8]
   assign thermometer_off     = pwr_one_reg[ipr_pkg::PWR_THERM_BIT]; // [R8]
   assign clock_source_select = pwr_one_reg[2:0];                    // [R8]
   assign power_control_two   = pwr_two_reg;
endmodule

// ---- sim/ipr_regs_properties.sv ----
`timescale 1ns/10ps
// ==========
// Port-level properties of the register slice.
// ==========
module ipr_regs_properties (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [6:0]  addr,
   input wire logic [7:0]  wdata,
   input wire logic [12:0] queue_level,
   input wire logic [7:0]  queue_rd_byte,
   input wire logic [7:0]  rdata,
   input wire logic        queue_pop,
   input wire logic        queue_push,
   input wire logic [7:0]  queue_wr_byte,
   input wire logic        device_reset_req,
   input wire logic        sleep_mode,
   input wire logic        accel_duty_cycling,
   input wire logic        rate_sensor_idle,
   input wire logic        thermometer_off,
   input wire logic [2:0]  clock_source_select,
   input wire logic [7:0]  power_control_two
);
   // One clock domain; a reset pass voids every check in flight.
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Power-control-one gathered back into its byte layout.
   wire logic [7:0] pwr_one = {device_reset_req, sleep_mode,
      accel_duty_cycling, rate_sensor_idle, thermometer_off,
      clock_source_select};
   AST_RESET_DEFAULT: assert property (
      $fell(rst) |-> pwr_one == ipr_pkg::PWR_ONE_RESET
      && power_control_two == 8'h00 && rdata == 8'h00)
      else $error("power control not at default after reset");
   AST_PWR_ONE_WRITE: assert property (
      wr_en && addr == ipr_pkg::ADDR_PWR_ONE && !device_reset_req
      |=> pwr_one == $past(wdata))
      else $error("power control one fields differ from written byte");
   AST_PWR_TWO_WRITE: assert property (
      wr_en && addr == ipr_pkg::ADDR_PWR_TWO && !device_reset_req
      |=> power_control_two == $past(wdata))
      else $error("power control two write lost");
   AST_DEVICE_RESET: assert property (
      device_reset_req |=> pwr_one == ipr_pkg::PWR_ONE_RESET
      && power_control_two == 8'h00)
      else $error("device reset did not reload power control");
   AST_LEVEL_HIGH: assert property (
      addr == ipr_pkg::ADDR_LEVEL_HIGH
      |=> rdata == {3'h0, $past(queue_level[12:8])})
      else $error("level high byte wrong");
   AST_LEVEL_LOW: assert property (
      addr == ipr_pkg::ADDR_LEVEL_LOW
      |=> rdata == $past(queue_level[7:0]))
      else $error("level low byte wrong");
   AST_IDENTITY: assert property (
      addr == ipr_pkg::ADDR_IDENTITY |=> rdata == ipr_pkg::IDENTITY_VALUE)
      else $error("identity byte wrong");
   AST_TRIM_LOW_BIT0: assert property (
      addr == ipr_pkg::ADDR_TRIM_X_LO || addr == ipr_pkg::ADDR_TRIM_Y_LO
      || addr == ipr_pkg::ADDR_TRIM_Z_LO |=> rdata[0] == 1'b0)
      else $error("unused trim bit reads one");
   AST_SLEEP_NO_PUSH: assert property (
      sleep_mode && wr_en && addr == ipr_pkg::ADDR_DATA_PORT |=> !queue_push)
      else $error("queue push taken while asleep");
   AST_AWAKE_PUSH: assert property (
      !sleep_mode && wr_en && addr == ipr_pkg::ADDR_DATA_PORT
      |=> queue_push && queue_wr_byte == $past(wdata))
      else $error("queue push missing while awake");
   // Main scenarios reached.
   cover property (device_reset_req);
   cover property (sleep_mode && wr_en && addr == ipr_pkg::ADDR_TRIM_X_HI);
   cover property (queue_pop);
endmodule

// ---- sim/ipr_queue_model.sv ----
`timescale 1ns/10ps
// ==========
// Behavioural queue behind the data port.
// ==========
module ipr_queue_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        pop,
   input  wire logic        push,
   output logic      [12:0] level,
   output logic      [7:0]  head
);
   // Starts part full so both count bytes carry non-zero bits.
   localparam logic [12:0] START_LEVEL = 13'h1234;
   // Head is a pattern of the level, so every pop changes it.
   assign head = level[7:0] ^ 8'hC3;
   // Count follows the pulses one edge later.
   always_ff @(posedge clk)
   begin
      if (rst)
         level <= START_LEVEL;
      else if (pop)
         level <= level - 13'h0001;
      else if (push)
         level <= level + 13'h0001;
   end
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
// ==========
// Host-side bench for the register slice.
// ==========
module testbench;
   logic        clk, rst, wr_en, rd_en, queue_pop, queue_push;
   logic        device_reset_req, sleep_mode, accel_duty_cycling;
   logic        rate_sensor_idle, thermometer_off;
   logic [2:0]  clock_source_select;
   logic [6:0]  addr;
   logic [7:0]  wdata, rdata, queue_rd_byte, queue_wr_byte;
   logic [7:0]  power_control_two;
   logic [12:0] queue_level;
   int          fails, num_checks;
   // Reset image: addresses and bytes, the last one unmapped.
   localparam logic [6:0] DEF_A [14] = '{7'h00, 7'h01, 7'h02, 7'h0D,
      7'h0E, 7'h0F, 7'h6B, 7'h6C, 7'h72, 7'h73, 7'h75, 7'h77, 7'h7E, 7'h10};
   localparam logic [7:0] DEF_D [14] = '{8'h80, 8'h80, 8'h80, 8'h70,
      8'h70, 8'h70, 8'h40, 8'h00, 8'h12, 8'h34, 8'hA5, 8'h00, 8'h00, 8'h00};
   ipr_regs i_ipr_regs (.clk, .rst, .wr_en, .rd_en, .addr, .wdata,
      .queue_level, .queue_rd_byte, .rdata, .queue_pop, .queue_push,
      .queue_wr_byte, .device_reset_req, .sleep_mode, .accel_duty_cycling,
      .rate_sensor_idle, .thermometer_off, .clock_source_select,
      .power_control_two);
   ipr_queue_model i_ipr_queue_model (.clk, .rst, .pop(queue_pop),
      .push(queue_push), .level(queue_level), .head(queue_rd_byte));
   // ==========
   // Clock and host tasks.
   // ==========
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Each of wr and rd opens on a fresh falling edge, so no strobe is set twice.
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      @(negedge clk);
      wr_en = 1'b0;
   endtask
   // Read byte is registered, so it is looked at one edge later.
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      @(negedge clk);
      addr = a;
      rd_en = 1'b1;
      @(negedge clk);
      rd_en = 1'b0;
      chk(rdata, e);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ==========
   // Test sequence.
   // ==========
   initial
   begin
      fails = 0;
      num_checks = 0;
      rst = 1'b1;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 7'h00;
      wdata = 8'h00;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      foreach (DEF_A[i])
         rd(DEF_A[i], DEF_D[i]);
      $display("test reset_defaults done");
      // Asleep: only the power-control bytes may change.
      wr(7'h77, 8'h12);
      wr(7'h74, 8'h55);
      wr(7'h6C, 8'h3F);
      chk(power_control_two, 8'h3F);
      rd(7'h77, 8'h00);
      rd(7'h6C, 8'h3F);
      rd(7'h73, 8'h34);
      // Wake with the three mode bits set and clock source 1, so those fields are seen as ones.
      wr(7'h6B, 8'h39);
      chk({7'h00, sleep_mode}, 8'h00);
      chk({5'h00, clock_source_select}, 8'h01);
      chk({5'h00, accel_duty_cycling, rate_sensor_idle,
         thermometer_off}, 8'h07);
      $display("test sleep_gate done");
      wr(7'h7A, 8'hAB);
      wr(7'h7E, 8'hFF);
      wr(7'h0E, 8'h5A);
      wr(7'h72, 8'hFF);
      rd(7'h7A, 8'hAB);
      rd(7'h7E, 8'hFE);
      // The host reads the stored code back before converting it.
      rd(7'h0E, 8'h5A);
      rd(7'h72, 8'h12);
      $display("test trim_and_readonly done");
      // A pop lowers the count; a push raises it back.
      rd(7'h74, 8'h34 ^ 8'hC3);
      chk({7'h00, queue_pop}, 8'h01);
      rd(7'h73, 8'h33);
      wr(7'h74, 8'h77);
      chk(queue_wr_byte, 8'h77);
      chk({7'h00, queue_push}, 8'h01);
      rd(7'h73, 8'h34);
      $display("test queue_port done");
      wr(7'h6B, 8'h80);
      chk({7'h00, device_reset_req}, 8'h01);
      rd(7'h6B, 8'h40);
      rd(7'h6C, 8'h00);
      chk(power_control_two, 8'h00);
      $display("test device_reset done");
      // A second reset after writes must bring back every image.
      wr(7'h6B, 8'h07);
      rst = 1'b1;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      foreach (DEF_A[i])
         rd(DEF_A[i], DEF_D[i]);
      $display("test second_reset done");
      tally_and_finish;
   end
   // The sequence needs about 110 cycles; eighteen times that means a hang.
   initial
   begin
      #100000;
      fails++;
      tally_and_finish;
   end
endmodule
bind ipr_regs ipr_regs_properties i_ipr_regs_properties (.clk, .rst,
   .wr_en, .rd_en, .addr, .wdata, .queue_level, .queue_rd_byte, .rdata,
   .queue_pop, .queue_push, .queue_wr_byte, .device_reset_req, .sleep_mode,
   .accel_duty_cycling, .rate_sensor_idle, .thermometer_off,
   .clock_source_select, .power_control_two);
